// ==== hw/otg_id_map.svh ====
// register offsets, field positions, reset values and timing counts of the id detection block
`ifndef OTG_ID_MAP_SVH
`define OTG_ID_MAP_SVH
// ==========================================
// register offsets (word index on the plain port)
`define ID_REG_CTRL 4'h0
`define ID_REG_USB_STAT 4'h1
`define ID_REG_CARKIT_STAT 4'h2
`define ID_REG_RISE_EN 4'h3
`define ID_REG_FALL_EN 4'h4
`define ID_REG_IRQ_STAT 4'h5
`define ID_REG_IRQ_MASK 4'h6
`define ID_REG_RID 4'h7
// ==========================================
// field positions
`define ID_CTRL_PULLUP_BIT 0
`define ID_CTRL_RID_START_BIT 1
`define ID_USB_GND_BIT 4
`define ID_CARKIT_OPEN_BIT 0
`define ID_EN_GND_BIT 4
`define ID_EN_OPEN_BIT 0
`define ID_IRQ_GND_BIT 0
`define ID_IRQ_OPEN_BIT 1
`define ID_IRQ_RID_BIT 2
// ==========================================
// reset values
`define ID_RESET_BYTE 8'h00
`define ID_RID_FLOAT 3'h5
// ==========================================
// timing: settle wait for the resistance converter
`define ID_RID_SETTLE_NS 1000
`define ID_CLK_NS 20
`define ID_RID_SETTLE_CYC ((`ID_RID_SETTLE_NS + `ID_CLK_NS - 1) / `ID_CLK_NS)
`endif

// ==== hw/otg_id_pkg.sv ====
// types shared by the id detection block
package otg_id_pkg;
  // resistance converter sequencer states, one-hot
  typedef enum logic [2:0] {
    RID_IDLE = 3'b001,
    RID_SETTLE = 3'b010,
    RID_DONE = 3'b100
  } rid_state_t;
  // resistance code type
  typedef logic [2:0] rid_code_t;
endpackage

// ==== hw/id_sync2.sv ====
// two flip-flop synchroniser for the analogue id comparator levels
`timescale 1ns/100ps
module id_sync2 #(
  parameter int W = 1
) (
  input wire logic mclk_i,
  input wire logic reset_n_i,
  input wire logic [W-1:0] async_i,
  output logic [W-1:0] sync_o
);
  // state of the synchroniser: both stages together
  typedef struct packed {
    logic [W-1:0] meta;
    logic [W-1:0] stable;
  } sync_state_t;
  sync_state_t s_q, s_d;
  // ==========================================
  // next state: first stage is read only by the second
  always_comb begin
    s_d = s_q;
    s_d.meta = async_i;
    s_d.stable = s_q.meta;
  end
  // register with synchronous reset to the "pin high" level
  always_ff @(posedge mclk_i) begin
    if (!reset_n_i) begin
      s_q <= '1;
    end else begin
      s_q <= s_d;
    end
  end
  assign sync_o = s_q.stable;
endmodule

// ==== hw/otg_id_detect.sv ====
// cable identification pin detection: pull-ups, comparators, events and resistance code
//
// Added by the designer: the plain strobed port and the address map.
`timescale 1ns/100ps
`include "otg_id_map.svh"
// Notes on behaviour
// - grounded status 0 for A, 1 for B
// - weak pull-up always on
// - any valid resistor pulls grounded comparator low (model: 102k and up keep it high with the strong pull-up on)
// - converter codes ground through floating, pull-up off
// - code readable in synchronous mode; start after ground
// - control bit connects strong 100k pull-up
// - open changes with enables raise alternate rxcmd flag
// - status pairs per termination with enables on
// - weak pull-up restores high after removal
// - grounded status in usb status bit 4
// - grounded changes interrupt per rise/fall enables
// - open status in carkit status bit 0
module otg_id_detect (
  input wire logic mclk_i,
  input wire logic reset_n_i,
  // plain register port
  input wire logic [3:0] reg_addr_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  output logic [7:0] reg_rdata_o,
  // analogue comparator and converter levels from the pin front end
  input wire logic id_gnd_cmp_i,
  input wire logic id_open_cmp_i,
  input wire logic [2:0] rid_adc_i,
  // analogue controls
  output logic id_strong_pullup_enable_o,
  output logic weak_id_pullup_o,
  output logic rid_conv_enable_o,
  // rxcmd alert and interrupt
  output logic rxcmd_alt_int_o,
  output logic rxcmd_req_o,
  output logic irq_o
);
  import otg_id_pkg::*;

  localparam int SETTLE_CYC = `ID_RID_SETTLE_CYC;

  // ==========================================
  // all block state but the synchroniser stages in one struct
  typedef struct packed {
    logic [7:0] ctrl;        // pull-up and converter start
    logic [7:0] rise_en;     // rising edge enables
    logic [7:0] fall_en;     // falling edge enables
    logic [7:0] irq_stat;    // sticky events
    logic [7:0] irq_mask;    // enables onto irq_o
    logic gnd_prev;          // last synchronised grounded level
    logic open_prev;         // last synchronised open level
    rid_state_t rid_st;      // converter sequencer
    logic [5:0] rid_cnt;     // settle counter
    rid_code_t rid_code;     // last measured code
    logic [7:0] rdata;       // read data stage
    logic alt_int;           // alternate flag of the rxcmd
    logic rx_req;            // rxcmd request pulse
    logic irq;               // interrupt level
    logic strong_pu;         // strong pull-up drive
    logic conv_en;           // converter power
    logic weak_pu; // weak pull-up drive, never released
  } id_state_t;
  id_state_t s_q, s_d;

  // synchronised comparator levels
  logic gnd_s; // grounded comparator, clock domain
  logic open_s; // open comparator, clock domain
  logic [1:0] cmp_s;
  // converter code is synchronised too; it only matters after the settle wait
  logic [2:0] rid_s;

  // ==========================================
  // comparator synchronisers
  // the comparators are analogue and may move at any time; two stages keep
  // metastability away from the edge detectors and the status bits
  id_sync2 #(.W(2)) u_sync_cmp (
    .mclk_i(mclk_i),
    .reset_n_i(reset_n_i),
    .async_i({id_open_cmp_i, id_gnd_cmp_i}),
    .sync_o(cmp_s)
  );
  id_sync2 #(.W(3)) u_sync_rid (
    .mclk_i(mclk_i),
    .reset_n_i(reset_n_i),
    .async_i(rid_adc_i),
    .sync_o(rid_s)
  );
  assign gnd_s = cmp_s[0];
  assign open_s = cmp_s[1];

  // ==========================================
  // next state
  always_comb begin
    logic gnd_rise;
    logic gnd_fall;
    logic open_rise;
    logic open_fall;
    logic gnd_evt;
    logic open_evt;
    logic rid_evt;
    logic [7:0] clr;
    gnd_rise = 1'b0;
    gnd_fall = 1'b0;
    open_rise = 1'b0;
    open_fall = 1'b0;
    gnd_evt = 1'b0;
    open_evt = 1'b0;
    rid_evt = 1'b0;
    clr = 8'h00;
    s_d = s_q;
    s_d.rx_req = 1'b0;
    s_d.gnd_prev = gnd_s;
    s_d.open_prev = open_s;
    // edges of the synchronised levels only, never the raw pins
    gnd_rise = gnd_s & ~s_q.gnd_prev;
    gnd_fall = ~gnd_s & s_q.gnd_prev;
    open_rise = open_s & ~s_q.open_prev;
    open_fall = ~open_s & s_q.open_prev;
    // grounded change gated by its own rise and fall enables
    gnd_evt = (gnd_rise & s_q.rise_en[`ID_EN_GND_BIT]) |
              (gnd_fall & s_q.fall_en[`ID_EN_GND_BIT]);
    // open change gated the same way, reported through the alternate flag
    open_evt = (open_rise & s_q.rise_en[`ID_EN_OPEN_BIT]) |
               (open_fall & s_q.fall_en[`ID_EN_OPEN_BIT]);
    // register writes
    // status and code indices are read-only, so writes to them are dropped
    if (reg_wr_i) begin
      if (reg_addr_i == `ID_REG_CTRL) begin
        s_d.ctrl = reg_wdata_i;
      end else if (reg_addr_i == `ID_REG_RISE_EN) begin
        s_d.rise_en = reg_wdata_i;
      end else if (reg_addr_i == `ID_REG_FALL_EN) begin
        s_d.fall_en = reg_wdata_i;
      end else if (reg_addr_i == `ID_REG_IRQ_STAT) begin
        clr = reg_wdata_i; // write one to clear
      end else if (reg_addr_i == `ID_REG_IRQ_MASK) begin
        s_d.irq_mask = reg_wdata_i;
      end
    end
    // converter sequencer: start bit self-clears once taken
    // the code is only taken after the settle wait, so the three converter
    // bits have long stopped moving by the time they are latched
    case (s_q.rid_st)
      RID_IDLE: begin
        if (s_q.ctrl[`ID_CTRL_RID_START_BIT]) begin
          s_d.ctrl[`ID_CTRL_RID_START_BIT] = 1'b0;
          s_d.rid_cnt = 6'(SETTLE_CYC - 1);
          s_d.rid_st = RID_SETTLE;
        end
      end
      RID_SETTLE: begin
        if (s_q.rid_cnt == 6'h00) begin
          s_d.rid_code = rid_s;
          s_d.rid_st = RID_DONE;
        end else begin
          s_d.rid_cnt = s_q.rid_cnt - 6'h01;
        end
      end
      RID_DONE: begin
        rid_evt = 1'b1;
        s_d.rid_st = RID_IDLE;
      end
      default: begin
        s_d.rid_st = RID_IDLE;
      end
    endcase
    // sticky status: a new event beats a clear in the same cycle
    // trade-off: a clear meeting a new event loses, so no change is ever missed
    s_d.irq_stat = s_q.irq_stat & ~clr;
    if (gnd_evt) begin
      s_d.irq_stat[`ID_IRQ_GND_BIT] = 1'b1;
    end
    if (open_evt) begin
      s_d.irq_stat[`ID_IRQ_OPEN_BIT] = 1'b1;
    end
    if (rid_evt) begin
      s_d.irq_stat[`ID_IRQ_RID_BIT] = 1'b1;
    end
    // rxcmd: any enabled change asks for one; open changes set alt_int
    // only the latest reason survives in alt_int; the status bits keep the rest
    if (gnd_evt | open_evt) begin
      s_d.rx_req = 1'b1;
      s_d.alt_int = open_evt;
    end
    s_d.irq = |(s_d.irq_stat & s_d.irq_mask);
    // strong pull-up follows its control bit directly
    s_d.strong_pu = s_d.ctrl[`ID_CTRL_PULLUP_BIT];
    // weak pull-up is held on in every state so an unplugged pin never floats
    s_d.weak_pu = 1'b1;
    // converter measures only with the strong pull-up off
    // limitation: a start written with the strong pull-up bit set runs the wait
    // with the converter unpowered, so the code it latches is not meaningful
    s_d.conv_en = (s_d.rid_st != RID_IDLE) & ~s_d.ctrl[`ID_CTRL_PULLUP_BIT];
    // read path, data one cycle after the strobe
    // status reads are live: they show the synchronised levels, not the
    // sticky bits, so a poll always sees the pin as it is now
    s_d.rdata = 8'h00;
    if (reg_rd_i) begin
      if (reg_addr_i == `ID_REG_CTRL) begin
        s_d.rdata = s_q.ctrl;
      end else if (reg_addr_i == `ID_REG_USB_STAT) begin
        // grounded level: 0 for an A plug, 1 for B or open
        s_d.rdata[`ID_USB_GND_BIT] = gnd_s;
      end else if (reg_addr_i == `ID_REG_CARKIT_STAT) begin
        s_d.rdata[`ID_CARKIT_OPEN_BIT] = open_s;
      end else if (reg_addr_i == `ID_REG_RISE_EN) begin
        s_d.rdata = s_q.rise_en;
      end else if (reg_addr_i == `ID_REG_FALL_EN) begin
        s_d.rdata = s_q.fall_en;
      end else if (reg_addr_i == `ID_REG_IRQ_STAT) begin
        s_d.rdata = s_q.irq_stat;
      end else if (reg_addr_i == `ID_REG_IRQ_MASK) begin
        s_d.rdata = s_q.irq_mask;
      end else if (reg_addr_i == `ID_REG_RID) begin
        // readable at any time in normal operation
        s_d.rdata = {5'h00, s_q.rid_code};
      end
    end
  end

  // ==========================================
  // state register, synchronous active low reset
  // the edge detectors start high like an unplugged pin, so no false edge
  // follows reset while nothing is attached
  always_ff @(posedge mclk_i) begin
    if (!reset_n_i) begin
      s_q <= '0;
      s_q.rid_st <= RID_IDLE;
      s_q.rid_code <= `ID_RID_FLOAT;
      s_q.gnd_prev <= 1'b1;
      s_q.open_prev <= 1'b1;
      s_q.weak_pu <= 1'b1;
    end else begin
      s_q <= s_d;
    end
  end

  // ==========================================
  // outputs straight from flip-flops
  assign reg_rdata_o = s_q.rdata;
  assign id_strong_pullup_enable_o = s_q.strong_pu;
  // the weak pull-up is never released; it keeps an unattached pin high
  assign weak_id_pullup_o = s_q.weak_pu;
  assign rid_conv_enable_o = s_q.conv_en;
  assign rxcmd_alt_int_o = s_q.alt_int;
  assign rxcmd_req_o = s_q.rx_req;
  assign irq_o = s_q.irq;

  // ==========================================
  // checks
  AST_GND_RISE_IRQ: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
    (reset_n_i && gnd_s && !s_q.gnd_prev && s_q.rise_en[`ID_EN_GND_BIT])
      |=> s_q.irq_stat[`ID_IRQ_GND_BIT] && s_q.rx_req)
    else $error("grounded rise did not latch");
  AST_OPEN_ALT: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
    (open_s != s_q.open_prev && s_q.rise_en[`ID_EN_OPEN_BIT] && s_q.fall_en[`ID_EN_OPEN_BIT])
      |=> s_q.alt_int && s_q.rx_req)
    else $error("open change gave no alternate rxcmd");
  AST_GND_READ: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
    (reg_rd_i && reg_addr_i == `ID_REG_USB_STAT)
      |=> reg_rdata_o == {3'h0, $past(gnd_s), 4'h0})
    else $error("grounded status not in bit 4");
  AST_OPEN_READ: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
    (reg_rd_i && reg_addr_i == `ID_REG_CARKIT_STAT)
      |=> reg_rdata_o == {7'h00, $past(open_s)})
    else $error("open status not in bit 0");
  // the strong pull-up follows bit 0 of a control write one cycle later
  AST_PULLUP: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
    (reg_wr_i && reg_addr_i == `ID_REG_CTRL)
      |=> id_strong_pullup_enable_o == $past(reg_wdata_i[0]))
    else $error("strong pull-up not following control");
  AST_WEAK: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
    weak_id_pullup_o)
    else $error("weak pull-up released");
  // the settle wait is fifty cycles, well inside this window
  AST_RID_TIME: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
    (s_q.rid_st == RID_IDLE && s_q.ctrl[1]) |=> s_q.rid_st == RID_SETTLE ##[1:60] s_q.rid_st == RID_DONE)
    else $error("converter did not finish in time");
  AST_RID_PU_OFF: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
    rid_conv_enable_o |-> !id_strong_pullup_enable_o)
    else $error("converter on with strong pull-up");
  // the interrupt line tracks the unmasked status bits in the same cycle
  AST_IRQ_LEVEL: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
    irq_o == |(s_q.irq_stat & s_q.irq_mask))
    else $error("interrupt level mismatch");
  // a rise held for two edges must reach the edge detector
  AST_SYNC: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
    $rose(id_gnd_cmp_i) ##1 id_gnd_cmp_i |-> ##1 gnd_s)
    else $error("grounded level not synchronised in two cycles");

  // ==========================================
  // checks on events, status and the converter
  // grounded fall is the A-plug arrival and must reach status and rxcmd
  AST_GND_FALL_IRQ: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
    (!gnd_s && s_q.gnd_prev && s_q.fall_en[`ID_EN_GND_BIT])
      |=> s_q.irq_stat[`ID_IRQ_GND_BIT] && s_q.rx_req)
    else $error("grounded fall did not latch");
  // a grounded-only change must not set the alternate flag
  AST_GND_NO_ALT: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
    (gnd_s != s_q.gnd_prev && s_q.rise_en[`ID_EN_GND_BIT] && s_q.fall_en[`ID_EN_GND_BIT]
      && open_s == s_q.open_prev)
      |=> s_q.rx_req && !s_q.alt_int)
    else $error("grounded change flagged as alternate");
  // no rxcmd without a synchronised comparator change
  AST_NO_SPURIOUS_REQ: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
    (gnd_s == s_q.gnd_prev && open_s == s_q.open_prev) |=> !s_q.rx_req)
    else $error("rxcmd without comparator change");
  // disabled edges leave the grounded status bit alone
  AST_GND_MASKED: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
    (!s_q.irq_stat[`ID_IRQ_GND_BIT] && !s_q.rise_en[`ID_EN_GND_BIT]
      && !s_q.fall_en[`ID_EN_GND_BIT]) |=> !s_q.irq_stat[`ID_IRQ_GND_BIT])
    else $error("grounded status set with its enables off");
  // a set status bit stays until software writes a one to it
  AST_GND_STICKY: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
    (s_q.irq_stat[`ID_IRQ_GND_BIT]
      && !(reg_wr_i && reg_addr_i == `ID_REG_IRQ_STAT && reg_wdata_i[`ID_IRQ_GND_BIT]))
      |=> s_q.irq_stat[`ID_IRQ_GND_BIT])
    else $error("grounded status lost without a clear");
  // the code read back is the one latched by the last measurement
  AST_RID_READ: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
    (reg_rd_i && reg_addr_i == `ID_REG_RID)
      |=> reg_rdata_o == {5'h00, $past(s_q.rid_code)})
    else $error("resistance code not readable");
  // the code is taken from the synchronised converter at the end of the wait
  AST_RID_LATCH: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
    (s_q.rid_st == RID_SETTLE && s_q.rid_cnt == 6'h00) |=> s_q.rid_code == $past(rid_s))
    else $error("resistance code not latched");
  // converter is powered for the whole wait while the strong pull-up is off
  AST_CONV_ON: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
    (s_q.rid_st == RID_SETTLE && !s_q.ctrl[`ID_CTRL_PULLUP_BIT]) |-> rid_conv_enable_o)
    else $error("converter off during measurement");
  // a grounded rise must not show before both synchroniser stages
  AST_SYNC_NOT_EARLY: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
    $rose(id_gnd_cmp_i) |=> !gnd_s)
    else $error("grounded level passed the synchroniser early");
  // grounded fall passes the synchroniser in two cycles as well
  AST_SYNC_FALL: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
    $fell(id_gnd_cmp_i) ##1 !id_gnd_cmp_i |-> ##1 !gnd_s)
    else $error("grounded fall not synchronised in two cycles");
endmodule

// ==== tb/id_term_model.sv ====
// behavioural model of the cable id termination and the analogue front end
`timescale 1ns/100ps
module id_term_model (
  input wire logic strong_pullup_i, // strong pull-up from the block
  input wire logic [2:0] term_i, // 0 gnd, 1 75r, 2 102k, 3 200k, 4 440k, 5 open
  output logic gnd_cmp_o, // grounded comparator level
  output logic open_cmp_o, // open comparator level
  output logic [2:0] rid_adc_o // converter code seen by the block
);
  // ==========================================
  // comparators: the weak pull-up loses against every valid resistor
  always_comb begin
    gnd_cmp_o = (term_i == 3'h5) | (strong_pullup_i & (term_i >= 3'h2));
    open_cmp_o = (term_i == 3'h5);
    // the code is only meaningful with the strong pull-up off, so garble it otherwise
    rid_adc_o = strong_pullup_i ? ~term_i : term_i;
  end
endmodule

// ==== tb/tb_otg_id_detect.sv ====
// self-checking testbench of the id pin detection block
`timescale 1ns/100ps
`include "otg_id_map.svh"
module tb_otg_id_detect;
  // ==========================================
  // clock, reset, bus and pin signals
  logic mclk_i = 1'b0;
  logic reset_n_i = 1'b0;
  logic [3:0] reg_addr = 4'h0;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [7:0] reg_rdata;
  logic [2:0] term = 3'h5; // termination index, cable starts unplugged
  logic gnd_cmp, open_cmp, strong_pu, weak_pu, conv_en, alt_int, rx_req, irq;
  logic [2:0] rid_adc;
  int errors = 0;
  int check_count = 0;
  int req_count = 0; // rxcmd request pulses seen
  logic last_alt = 1'b0; // alternate flag beside the last request
  int i;
  otg_id_detect dut_u (.mclk_i(mclk_i), .reset_n_i(reset_n_i), .reg_addr_i(reg_addr),
    .reg_wdata_i(reg_wdata), .reg_wr_i(reg_wr), .reg_rd_i(reg_rd), .reg_rdata_o(reg_rdata),
    .id_gnd_cmp_i(gnd_cmp), .id_open_cmp_i(open_cmp), .rid_adc_i(rid_adc),
    .id_strong_pullup_enable_o(strong_pu), .weak_id_pullup_o(weak_pu),
    .rid_conv_enable_o(conv_en), .rxcmd_alt_int_o(alt_int), .rxcmd_req_o(rx_req), .irq_o(irq));
  id_term_model pin_u (.strong_pullup_i(strong_pu), .term_i(term), .gnd_cmp_o(gnd_cmp),
    .open_cmp_o(open_cmp), .rid_adc_o(rid_adc));
  // ==========================================
  // clock and rxcmd monitor
  initial begin
    forever #10 mclk_i = ~mclk_i;
  end
  // a request stands one cycle, so it is caught at every edge
  always @(posedge mclk_i) begin
    if (rx_req === 1'b1) begin
      req_count <= req_count + 1;
      last_alt <= alt_int;
    end
  end
  // ==========================================
  // tasks
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    check_count++;
    if (got !== exp) begin
      errors++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge mclk_i);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge mclk_i);
    reg_wr <= 1'b0;
  endtask
  // read data stand only in the cycle after the strobe
  task automatic rd_chk(input logic [3:0] a, input logic [7:0] exp);
    @(posedge mclk_i);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge mclk_i);
    reg_rd <= 1'b0;
    #1;
    chk(reg_rdata, exp);
  endtask
  // change the cable, then leave room for the two synchroniser stages
  task automatic set_term(input logic [2:0] t);
    @(posedge mclk_i);
    term <= t;
    repeat (6) @(posedge mclk_i);
    #1;
  endtask
  task automatic results;
    $display("checks=%0d errors=%0d", check_count, errors);
    if (errors == 0 && check_count > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  // ==========================================
  // watchdog: the sequence needs well under 2000 cycles
  initial begin
    repeat (20000) @(posedge mclk_i);
    errors++;
    results();
  end
  // ==========================================
  // main sequence
  initial begin
    repeat (10) @(posedge mclk_i);
    reset_n_i <= 1'b1;
    #1;
    chk({7'h00, weak_pu}, 8'h01);
    rd_chk(`ID_REG_RID, 8'h05);
    @(posedge mclk_i);
    #1;
    chk(reg_rdata, 8'h00);
    rd_chk(4'h8, 8'h00);
    rd_chk(`ID_REG_IRQ_STAT, 8'h00);
    // link turns the strong pull-up on; the model settles at once, so a short wait stands in
    wr(`ID_REG_CTRL, 8'h01);
    repeat (5) @(posedge mclk_i);
    #1;
    chk({7'h00, strong_pu}, 8'h01);
    rd_chk(`ID_REG_USB_STAT, 8'h10);
    rd_chk(`ID_REG_CARKIT_STAT, 8'h01);
    wr(`ID_REG_RISE_EN, 8'h11);
    wr(`ID_REG_FALL_EN, 8'h11);
    wr(`ID_REG_IRQ_MASK, 8'h07);
    // 102k: only the open comparator falls, nothing before the synchroniser
    @(posedge mclk_i);
    term <= 3'h2;
    @(posedge mclk_i);
    #1;
    chk({7'h00, irq}, 8'h00);
    repeat (5) @(posedge mclk_i);
    #1;
    chk({7'h00, irq}, 8'h01);
    chk({7'h00, last_alt}, 8'h01);
    chk(req_count[7:0], 8'h01);
    rd_chk(`ID_REG_IRQ_STAT, 8'h01 << `ID_IRQ_OPEN_BIT);
    rd_chk(`ID_REG_USB_STAT, 8'h10);
    rd_chk(`ID_REG_CARKIT_STAT, 8'h00);
    wr(`ID_REG_IRQ_STAT, 8'h02);
    // ground: grounded comparator falls
    set_term(3'h0);
    chk({7'h00, last_alt}, 8'h00);
    chk(req_count[7:0], 8'h02);
    rd_chk(`ID_REG_IRQ_STAT, 8'h01 << `ID_IRQ_GND_BIT);
    rd_chk(`ID_REG_USB_STAT, 8'h00);
    wr(`ID_REG_IRQ_STAT, 8'h01);
    @(posedge mclk_i);
    #1;
    chk({7'h00, irq}, 8'h00);
    // back to 102k: grounded comparator rises
    set_term(3'h2);
    rd_chk(`ID_REG_IRQ_STAT, 8'h01);
    wr(`ID_REG_IRQ_STAT, 8'h01);
    // masked event keeps the line low while status is set
    wr(`ID_REG_IRQ_MASK, 8'h00);
    set_term(3'h0);
    chk({7'h00, irq}, 8'h00);
    rd_chk(`ID_REG_IRQ_STAT, 8'h01);
    wr(`ID_REG_IRQ_STAT, 8'h07);
    // a plug seen: save current, then pull the cable out
    wr(`ID_REG_CTRL, 8'h00);
    wr(`ID_REG_RISE_EN, 8'h00);
    wr(`ID_REG_FALL_EN, 8'h00);
    set_term(3'h5);
    rd_chk(`ID_REG_USB_STAT, 8'h10);
    rd_chk(`ID_REG_IRQ_STAT, 8'h00);
    // resistance converter over every termination, pull-up off
    wr(`ID_REG_IRQ_MASK, 8'h04);
    for (i = 0; i < 6; i++) begin
      set_term(i[2:0]);
      rd_chk(`ID_REG_USB_STAT, (i == 5) ? 8'h10 : 8'h00);
      wr(`ID_REG_CTRL, 8'h02);
      repeat (3) @(posedge mclk_i);
      #1;
      chk({7'h00, conv_en}, 8'h01);
      repeat (`ID_RID_SETTLE_CYC + 10) @(posedge mclk_i);
      #1;
      chk({7'h00, irq}, 8'h01);
      rd_chk(`ID_REG_RID, {5'h00, i[2:0]});
      rd_chk(`ID_REG_IRQ_STAT, 8'h01 << `ID_IRQ_RID_BIT);
      chk({7'h00, conv_en}, 8'h00);
      wr(`ID_REG_IRQ_STAT, 8'h04);
    end
    // a second reset in mid-run returns controls to their idle values
    wr(`ID_REG_CTRL, 8'h01);
    wr(`ID_REG_IRQ_MASK, 8'h07);
    reset_n_i <= 1'b0;
    repeat (3) @(posedge mclk_i);
    reset_n_i <= 1'b1;
    #1;
    chk({7'h00, strong_pu}, 8'h00);
    chk({6'h00, weak_pu, irq}, 8'h02);
    rd_chk(`ID_REG_IRQ_MASK, 8'h00);
    rd_chk(`ID_REG_CTRL, 8'h00);
    results();
  end
endmodule
